// file: rtl/shfx_field_mask.sv
`timescale 1ns/1ps

module shfx_field_mask #(
  parameter int W = 32
) (
  input  logic [5:0]   pos_i,
  input  logic [5:0]   len_i,
  output logic [W-1:0] low_m_o,
  output logic [W-1:0] field_m_o,
  output logic [W-1:0] above_m_o
);

  if ((W < 1) || (W > 64)) begin : g_chk
    $error("shfx_field_mask: W must be 1..64");
  end

  logic [6:0] top;

  assign top = {1'b0, pos_i} + {1'b0, len_i};

  // positions past the word simply never match, so off-scale fields shrink
  for (genvar i = 0; i < W; i++) begin : g_bit
    localparam logic [6:0] IDX = 7'(i);
    assign low_m_o[i]   = (IDX < {1'b0, len_i});
    assign field_m_o[i] = (IDX >= {1'b0, pos_i}) & (IDX < top);
    assign above_m_o[i] = (IDX >= top);
  end

endmodule : shfx_field_mask

// file: rtl/shfx_lead_count.sv
`timescale 1ns/1ps

module shfx_lead_count #(
  parameter int W  = 32,
  parameter int CW = 6
) (
  input  logic [W-1:0]  val_i,
  input  logic          pol_i,
  output logic [CW-1:0] count_o
);

  if ((W < 2) || ($clog2(W + 1) > CW)) begin : g_chk
    $error("shfx_lead_count: CW too narrow for W");
  end

  logic [W-1:0] run;

  // run[i] is high while every bit from the top down to i matches pol_i
  assign run[W-1] = (val_i[W-1] == pol_i);
  for (genvar i = 0; i < W - 1; i++) begin : g_run
    assign run[i] = run[i+1] & (val_i[i] == pol_i);
  end

  always_comb begin
    count_o = '0;
    for (int k = 0; k < W; k++) begin
      count_o = count_o + CW'(run[k]);
    end
  end

endmodule : shfx_lead_count

// file: rtl/shfx_params.svh
`ifndef SHFX_PARAMS_SVH
`define SHFX_PARAMS_SVH

// register byte offsets
`define SHFX_OFF_SRC    8'h00
`define SHFX_OFF_CTRL   8'h04
`define SHFX_OFF_DFX    8'h08
`define SHFX_OFF_DEXT   8'h0C
`define SHFX_OFF_CMD    8'h10
`define SHFX_OFF_FLAGS  8'h14
`define SHFX_OFF_IST    8'h18
`define SHFX_OFF_IMSK   8'h1C

// control operand layout
`define SHFX_POS_LSB    0
`define SHFX_LEN_LSB    6

// fixed-point field width as a 7-bit limit
`define SHFX_FX_LIMIT   7'h20
`define SHFX_CNT_FULL   6'h20
`define SHFX_EXP_AV     8'h01

// reset values
`define SHFX_RST_WORD   32'h0000_0000
`define SHFX_RST_EXT    8'h00
`define SHFX_RST_FLAGS  3'h0
`define SHFX_RST_IRQ    2'h0

`define SHFX_RESP_OKAY  2'h0
`define SHFX_RESP_SLV   2'h2

`endif

// file: rtl/shfx_pkg.sv
package shfx_pkg;

  typedef enum logic [2:0] {
    SHFX_OP_DEP    = 3'b000,
    SHFX_OP_DEP_OR = 3'b001,
    SHFX_OP_EXT    = 3'b010,
    SHFX_OP_EXP    = 3'b011,
    SHFX_OP_CLZ    = 3'b100,
    SHFX_OP_CLO    = 3'b101
  } shfx_op_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic        alu_overflow_flag;
    logic [5:0]  imm_length;
    logic [5:0]  imm_position;
    logic        use_immediate;
    logic        alu_result_option;
    logic        sign_extend_option;
    logic [2:0]  op;
  } shfx_cmd_t;

  typedef struct packed {
    logic sign;
    logic shifter_overflow_flag;
    logic shifter_zero_flag;
  } shfx_flags_t;

  typedef struct packed {
    logic ovf;
    logic done;
  } shfx_irq_t;

endpackage : shfx_pkg

// file: rtl/shfx_unit.sv
`timescale 1ns/1ps
`include "shfx_params.svh"


module shfx_unit
  import shfx_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  logic              clk_i,
  input  logic              reset_n_i,
  input  logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  logic              s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  logic [31:0]       s_axi_wdata_i,
  input  logic [3:0]        s_axi_wstrb_i,
  input  logic              s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  logic              s_axi_bready_i,
  input  logic [ADDR_W-1:0] s_axi_araddr_i,
  input  logic              s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  logic              s_axi_rready_i,
  output logic              irq_o
);

  if ((ADDR_W < 8) || (ADDR_W > 32)) begin : g_chk
    $error("shfx_unit: ADDR_W must be 8..32");
  end

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // ---------------- bus slave: write side
  logic              aw_have_q;
  logic              w_have_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_hs;
  logic              w_hs;
  logic              wr_fire;
  logic [7:0]        wa;
  logic              wr_hit;

  assign aw_hs   = s_axi_awvalid_i & awready_q;
  assign w_hs    = s_axi_wvalid_i & wready_q;
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wa      = {awaddr_q[7:2], 2'b00};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= '0;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      awready_q <= wr_fire | (~aw_have_q & ~aw_hs);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= `SHFX_RST_WORD;
      wstrb_q  <= 4'h0;
    end else begin
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
      wready_q <= wr_fire | (~w_have_q & ~w_hs);
    end
  end

  always_comb begin
    wr_hit = (awaddr_q >> 8) == '0;
    case (wa)
      `SHFX_OFF_SRC, `SHFX_OFF_CTRL, `SHFX_OFF_DFX, `SHFX_OFF_DEXT,
      `SHFX_OFF_CMD, `SHFX_OFF_FLAGS, `SHFX_OFF_IST, `SHFX_OFF_IMSK: begin
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SHFX_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `SHFX_RESP_OKAY : `SHFX_RESP_SLV;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  logic wr_src;
  logic wr_ctrl;
  logic wr_dfx;
  logic wr_dext;
  logic wr_cmd;
  logic wr_ist;
  logic wr_imsk;

  assign wr_src  = wr_fire & wr_hit & (wa == `SHFX_OFF_SRC);
  assign wr_ctrl = wr_fire & wr_hit & (wa == `SHFX_OFF_CTRL);
  assign wr_dfx  = wr_fire & wr_hit & (wa == `SHFX_OFF_DFX);
  assign wr_dext = wr_fire & wr_hit & (wa == `SHFX_OFF_DEXT);
  assign wr_cmd  = wr_fire & wr_hit & (wa == `SHFX_OFF_CMD);
  assign wr_ist  = wr_fire & wr_hit & (wa == `SHFX_OFF_IST);
  assign wr_imsk = wr_fire & wr_hit & (wa == `SHFX_OFF_IMSK);

  // ---------------- operand registers
  logic [31:0] src_q;
  logic [31:0] ctrl_q;
  logic [31:0] dest_fx_q;
  logic [7:0]  dest_ext_q;
  shfx_flags_t flags_q;
  shfx_irq_t   ist_q;
  shfx_irq_t   imsk_q;
  logic        irq_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_q  <= `SHFX_RST_WORD;
      ctrl_q <= `SHFX_RST_WORD;
    end else begin
      if (wr_src) begin
        src_q <= strb_merge(src_q, wdata_q, wstrb_q);
      end
      if (wr_ctrl) begin
        ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q);
      end
    end
  end

  // ---------------- command decode
  shfx_cmd_t  cmd;
  logic       issue;
  logic       se;
  logic       arv;
  logic       av;
  logic [5:0] pos;
  logic [5:0] len;
  logic [5:0] lm1;
  logic [6:0] fld_sum;
  logic       fx_ovf;
  logic       len_ok;

  // a command word carries the whole instruction, so strobes are not applied
  assign cmd   = shfx_cmd_t'(wdata_q);
  assign issue = wr_cmd & (cmd.op <= SHFX_OP_CLO);
  assign se    = cmd.sign_extend_option;
  assign arv   = cmd.alu_result_option;
  assign av    = cmd.alu_overflow_flag;

  assign pos = cmd.use_immediate ? cmd.imm_position : ctrl_q[`SHFX_POS_LSB +: 6];
  assign len = cmd.use_immediate ? cmd.imm_length : ctrl_q[`SHFX_LEN_LSB +: 6];
  assign lm1     = len - 6'h01;
  assign fld_sum = {1'b0, pos} + {1'b0, len};
  assign fx_ovf  = fld_sum > `SHFX_FX_LIMIT;
  assign len_ok  = (len != 6'h00) & (len <= `SHFX_CNT_FULL);

  logic [31:0] low_m;
  logic [31:0] field_m;
  logic [31:0] above_m;
  logic [31:0] below_m;

  shfx_field_mask #(
    .W(32)
  ) u_mask (
    .pos_i    (pos),
    .len_i    (len),
    .low_m_o  (low_m),
    .field_m_o(field_m),
    .above_m_o(above_m)
  );

  assign below_m = ~(field_m | above_m);

  // ---------------- deposit
  logic [63:0] dep_wide;
  logic        dep_sign;
  logic [31:0] dep_val;

  assign dep_wide = {32'h0, src_q & low_m} << pos;
  assign dep_sign = len_ok & src_q[lm1[4:0]];
  // above_m is empty once the field top runs off-scale, which drops the fill
  assign dep_val = dep_wide[31:0] | ((se & dep_sign) ? above_m : 32'h0);

  // ---------------- extract
  logic [63:0] ext_wide;
  logic        ext_sign;
  logic [31:0] ext_val;

  assign ext_wide = {32'h0, src_q} >> pos;
  assign ext_sign = len_ok & ~fx_ovf & ext_wide[lm1[4:0]];
  assign ext_val  = (ext_wide[31:0] & low_m) | ((se & ext_sign) ? ~low_m : 32'h0);

  // ---------------- exponent and leading counts
  logic [5:0] n_lead;
  logic [7:0] exp_plain;
  logic [7:0] exp_val;
  logic       exp_sign;
  logic [5:0] clz;
  logic [5:0] clo;

  // one counter serves all three: it counts copies of the top bit
  shfx_lead_count #(
    .W (32),
    .CW(6)
  ) u_lead (
    .val_i  (src_q),
    .pol_i  (src_q[31]),
    .count_o(n_lead)
  );

  assign exp_plain = 8'h01 - {2'b00, n_lead};
  assign exp_val   = (arv & av) ? `SHFX_EXP_AV : exp_plain;
  assign exp_sign  = arv ? (av ^ src_q[31]) : src_q[31];
  assign clz       = src_q[31] ? 6'h00 : n_lead;
  assign clo       = src_q[31] ? n_lead : 6'h00;

  // ---------------- result select
  logic [31:0] res_fx;
  logic [7:0]  res_ext;
  shfx_flags_t res_flags;

  always_comb begin
    res_fx    = 32'h0;
    res_ext   = `SHFX_RST_EXT;
    res_flags = '0;
    case (cmd.op)
      SHFX_OP_DEP: begin
        res_fx = dep_val;
        res_flags.shifter_overflow_flag = fx_ovf;
        res_flags.shifter_zero_flag     = (dep_val == 32'h0);
      end
      SHFX_OP_DEP_OR: begin
        res_fx = dep_val | dest_fx_q;
        res_flags.shifter_overflow_flag = fx_ovf;
        res_flags.shifter_zero_flag     = ((dep_val | dest_fx_q) == 32'h0);
      end
      SHFX_OP_EXT: begin
        res_fx = ext_val;
        res_flags.shifter_overflow_flag = fx_ovf;
        res_flags.shifter_zero_flag     = (ext_val == 32'h0);
      end
      SHFX_OP_EXP: begin
        res_fx = {24'h0, exp_val};
        res_flags.shifter_zero_flag = (exp_val == 8'h00);
        res_flags.sign              = exp_sign;
      end
      SHFX_OP_CLZ: begin
        res_fx = {26'h0, clz};
        res_flags.shifter_zero_flag     = src_q[31];
        res_flags.shifter_overflow_flag = (clz == `SHFX_CNT_FULL);
      end
      SHFX_OP_CLO: begin
        res_fx = {26'h0, clo};
        res_flags.shifter_zero_flag     = ~src_q[31];
        res_flags.shifter_overflow_flag = (clo == `SHFX_CNT_FULL);
      end
      default: begin
      end
    endcase
  end

  // destination and flags move on the same edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dest_fx_q  <= `SHFX_RST_WORD;
      dest_ext_q <= `SHFX_RST_EXT;
    end else if (issue) begin
      dest_fx_q  <= res_fx;
      dest_ext_q <= res_ext;
    end else begin
      if (wr_dfx) begin
        dest_fx_q <= strb_merge(dest_fx_q, wdata_q, wstrb_q);
      end
      if (wr_dext && wstrb_q[0]) begin
        dest_ext_q <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= `SHFX_RST_FLAGS;
    end else if (issue) begin
      flags_q <= res_flags;
    end
  end

  // ---------------- interrupts
  shfx_irq_t ist_set;
  shfx_irq_t ist_clr;

  assign ist_set.done = issue;
  assign ist_set.ovf  = issue & res_flags.shifter_overflow_flag;
  assign ist_clr      = wr_ist ? shfx_irq_t'(wdata_q[1:0]) : `SHFX_RST_IRQ;

  // a set in the same cycle as its clear survives
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ist_q  <= `SHFX_RST_IRQ;
      imsk_q <= `SHFX_RST_IRQ;
      irq_q  <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ist_set;
      if (wr_imsk) begin
        imsk_q <= shfx_irq_t'(wdata_q[1:0]);
      end
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // ---------------- bus slave: read side
  logic        ar_hs;
  logic        rd_done;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  ra;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign ar_hs   = s_axi_arvalid_i & arready_q;
  assign rd_done = rvalid_q & s_axi_rready_i;
  assign ra      = {s_axi_araddr_i[7:2], 2'b00};

  always_comb begin
    rd_hit  = (s_axi_araddr_i >> 8) == '0;
    rd_word = 32'h0;
    case (ra)
      `SHFX_OFF_SRC:   rd_word = src_q;
      `SHFX_OFF_CTRL:  rd_word = ctrl_q;
      `SHFX_OFF_DFX:   rd_word = dest_fx_q;
      `SHFX_OFF_DEXT:  rd_word = {24'h0, dest_ext_q};
      `SHFX_OFF_CMD:   rd_word = 32'h0;
      `SHFX_OFF_FLAGS: rd_word = {29'h0, flags_q};
      `SHFX_OFF_IST:   rd_word = {30'h0, ist_q};
      `SHFX_OFF_IMSK:  rd_word = {30'h0, imsk_q};
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (!rd_hit) begin
      rd_word = 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= `SHFX_RST_WORD;
      rresp_q   <= `SHFX_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? `SHFX_RESP_OKAY : `SHFX_RESP_SLV;
      end else if (rd_done) begin
        rvalid_q <= 1'b0;
      end
      arready_q <= rd_done | (~rvalid_q & ~ar_hs);
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign irq_o           = irq_q;

  // ---------------- checks
  logic is_fld;
  logic is_dep;

  assign is_dep = (cmd.op == SHFX_OP_DEP) | (cmd.op == SHFX_OP_DEP_OR);
  assign is_fld = is_dep | (cmd.op == SHFX_OP_EXT);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_ext_zero: assert property (
    issue && is_fld |=> dest_ext_q == 8'h00)
    else $error("extension field not cleared");

  a_ovf_field: assert property (
    issue && is_fld |=> flags_q.shifter_overflow_flag == $past(fx_ovf))
    else $error("field overflow flag wrong");

  a_zero_result: assert property (
    issue && is_fld |=> flags_q.shifter_zero_flag == (dest_fx_q == 32'h0))
    else $error("zero flag disagrees with result");

  a_sign_clear: assert property (
    issue && (cmd.op != SHFX_OP_EXP) |=> !flags_q.sign)
    else $error("sign flag not cleared");

  a_below_zero: assert property (
    issue && (cmd.op == SHFX_OP_DEP) |=> (dest_fx_q & $past(below_m)) == 32'h0)
    else $error("bits below deposit not zero");

  a_or_keep: assert property (
    issue && (cmd.op == SHFX_OP_DEP_OR) |=> (dest_fx_q | $past(dest_fx_q)) == dest_fx_q)
    else $error("or-merge lost old bits");

  a_exp_plus1: assert property (
    issue && (cmd.op == SHFX_OP_EXP) && arv && av |=> dest_fx_q == 32'h1 && !flags_q.shifter_zero_flag)
    else $error("exponent with alu overflow not +1");

  a_exp_sign: assert property (
    issue && (cmd.op == SHFX_OP_EXP) |=> flags_q.sign == ($past(src_q[31]) ^ ($past(arv) & $past(av)))
      && !flags_q.shifter_overflow_flag)
    else $error("exponent sign or overflow wrong");

  a_clz_full: assert property (
    issue && (cmd.op == SHFX_OP_CLZ) && (src_q == 32'h0)
      |=> dest_fx_q == 32'h20 && flags_q.shifter_overflow_flag && !flags_q.shifter_zero_flag)
    else $error("leading zero count of zero wrong");

  a_clo_zero: assert property (
    issue && (cmd.op == SHFX_OP_CLO) && !src_q[31]
      |=> dest_fx_q == 32'h0 && flags_q.shifter_zero_flag)
    else $error("leading one count flags wrong");

  a_resp_follow: assert property (
    wr_fire |=> bvalid_q && awready_q && wready_q)
    else $error("write response missing");

  a_resp_hold: assert property (
    bvalid_q && !s_axi_bready_i |=> bvalid_q)
    else $error("write response dropped early");

endmodule : shfx_unit

// file: test/shfx_axi_host.sv
`timescale 1ns/1ps

// software side of the register bus; idle address and write-data lines carry the inverse of the last value, strobes keep theirs
module shfx_axi_host (
  input  logic        clk_i,
  output logic [7:0]  awaddr_o,
  output logic        awvalid_o,
  input  logic        awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0]  wstrb_o,
  output logic        wvalid_o,
  input  logic        wready_i,
  input  logic [1:0]  bresp_i,
  input  logic        bvalid_i,
  output logic        bready_o,
  output logic [7:0]  araddr_o,
  output logic        arvalid_o,
  input  logic        arready_i,
  input  logic [31:0] rdata_i,
  input  logic [1:0]  rresp_i,
  input  logic        rvalid_i,
  output logic        rready_o,
  output logic        hung_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o, hung_o} = '0;
    wstrb_o = 4'hF;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end while (!bvalid_i && n < 200);
    r = bresp_i;
    bready_o <= 1'b0;
    if (n >= 200) hung_o <= 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
    end while (!rvalid_i && n < 200);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
    if (n >= 200) hung_o <= 1'b1;
  endtask : rd

  task automatic set_strb(input logic [3:0] be);
    wstrb_o <= be;
  endtask : set_strb
endmodule : shfx_axi_host

// file: test/shfx_unit_tb_top.sv
`timescale 1ns/1ps
`include "shfx_params.svh"

module shfx_unit_tb_top;
  logic        clk, rst_n, irq, hung;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, s, c, d, cm, got, erd, ist, mk, clr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  efl;
  int          n_mismatch, n_checks, seed, i;

  always #5 clk = ~clk;

  shfx_unit #(.ADDR_W(8)) dut (
    .clk_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .irq_o(irq)
  );

  shfx_axi_host m (
    .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
    .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready), .hung_o(hung)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  always @(posedge hung) begin
    n_mismatch++;
    test_done();
  end

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    m.rd(a, got, rsp);
    chk_word(nm, e, got);
    chk_resp(nm, `SHFX_RESP_OKAY, rsp);
  endtask : rdc

  // reference result; flags packed as sign, overflow, zero
  function automatic void model(input logic [31:0] xs, xc, xd, xm, output logic [31:0] r, output logic [2:0] fl);
    int op, l, p, n, e, t;
    logic [63:0] f;
    op = int'(xm[2:0]);
    p = xm[5] ? int'(xm[11:6]) : int'(xc[5:0]);
    l = xm[5] ? int'(xm[17:12]) : int'(xc[11:6]);
    fl = 3'h0;
    if (op < 3) begin
      f = {32'h0, xs};
      if (op == 2) f = f >> p;
      f = f & ((64'h1 << (l > 32 ? 32 : l)) - 64'h1);
      if (op != 2) f = f << p;
      t = (op == 2) ? l : p + l;
      // no sign fill once the field top bit is off-scale
      if (xm[3] && l > 0 && l + p <= 32 && f[t - 1]) f = f | (~64'h0 << t);
      r = f[31:0];
      if (op == 1) r = r | xd;
      fl[1] = l + p > 32;
      fl[0] = r == 0;
    end else if (op == 3) begin
      n = 1;
      while (n < 32 && xs[31 - n] == xs[31]) n++;
      e = (xm[4] && xm[18]) ? 1 : 1 - n;
      r = {24'h0, 8'(e)};
      fl[0] = e == 0;
      fl[2] = xm[4] ? xm[18] ^ xs[31] : xs[31];
    end else begin
      n = 0;
      while (n < 32 && xs[31 - n] == (op == 5)) n++;
      r = 32'(n);
      fl[1] = n == 32;
      fl[0] = xs[31] == (op == 4);
    end
  endfunction : model

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    seed = 51;
    ist = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 8; i++) rdc("reset value", 8'(4 * i), 32'h0000_0000);
    m.wr(`SHFX_OFF_FLAGS, 32'h0000_0007, rsp);
    rdc("flags read only", `SHFX_OFF_FLAGS, 32'h0000_0000);
    m.wr(8'h20, 32'h0000_0001, rsp);
    chk_resp("write unmapped", `SHFX_RESP_SLV, rsp);
    m.rd(8'h20, got, rsp);
    chk_resp("read unmapped", `SHFX_RESP_SLV, rsp);
    chk_word("read unmapped", 32'h0000_0000, got);
    m.set_strb(4'h2);
    m.wr(`SHFX_OFF_SRC, 32'h1234_5678, rsp);
    m.wr(`SHFX_OFF_DEXT, 32'h0000_00AB, rsp);
    m.set_strb(4'hF);
    rdc("byte strobe", `SHFX_OFF_SRC, 32'h0000_5600);
    rdc("ext strobe", `SHFX_OFF_DEXT, 32'h0000_0000);
    $display("test registers done");
    for (i = 0; i < 120; i++) begin
      s = $random(seed);
      c = $random(seed);
      d = $random(seed);
      cm = $random(seed);
      mk = $random(seed) & 3;
      cm[2:0] = 3'(i % 6);
      if (i % 7 == 1) s = 32'h0000_0000;
      if (i % 7 == 2) s = 32'hFFFF_FFFF;
      // length plus position at and just past the 32-bit edge
      if ((i / 6) % 2 == 0) begin
        c[11:6] = 6'(i % 34);
        c[5:0] = 6'(32 - i % 34 + i % 3);
        cm[17:6] = c[11:0];
      end
      m.wr(`SHFX_OFF_SRC, s, rsp);
      m.wr(`SHFX_OFF_CTRL, c, rsp);
      m.wr(`SHFX_OFF_DFX, d, rsp);
      m.wr(`SHFX_OFF_DEXT, 32'h0000_00FF, rsp);
      m.wr(`SHFX_OFF_IMSK, mk, rsp);
      m.wr(`SHFX_OFF_CMD, cm, rsp);
      chk_resp("cmd write", `SHFX_RESP_OKAY, rsp);
      model(s, c, d, cm, erd, efl);
      ist = ist | {30'h0, efl[1], 1'b1};
      rdc("dest", `SHFX_OFF_DFX, erd);
      rdc("ext", `SHFX_OFF_DEXT, 32'h0000_0000);
      rdc("flags", `SHFX_OFF_FLAGS, {29'h0, efl});
      rdc("irq status", `SHFX_OFF_IST, ist);
      chk_bit("irq", |(ist[1:0] & mk[1:0]), irq);
      clr = $random(seed) & 3;
      m.wr(`SHFX_OFF_IST, clr, rsp);
      ist = ist & ~clr;
    end
    $display("test operations done");
    m.wr(`SHFX_OFF_CMD, 32'h0000_0006, rsp);
    m.wr(`SHFX_OFF_CMD, 32'h0000_0007, rsp);
    chk_resp("ignored op", `SHFX_RESP_OKAY, rsp);
    rdc("ignored op dest", `SHFX_OFF_DFX, erd);
    rdc("ignored op flags", `SHFX_OFF_FLAGS, {29'h0, efl});
    rdc("ignored op status", `SHFX_OFF_IST, ist);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("reset again", `SHFX_OFF_DFX, 32'h0000_0000);
    rdc("reset again", `SHFX_OFF_IST, 32'h0000_0000);
    chk_bit("irq after reset", 1'b0, irq);
    $display("test ignored ops and reset done");
    test_done();
  end
endmodule : shfx_unit_tb_top
